/* File: src/bbdt_defines.vh */
// Constants for the billboard detach timer B block
// Behaviour
// - Timeout starts when host requests alt-mode string
// - On expiry detach, then re-attach default personality
// - Timeout value counts 10 ms units
// - Reset timeout value 07D0h, twenty seconds
// - Timeout split over low and high bytes
// - Alt-mode and URL string indices configurable
// - Either timer expiry forces detach like unplug
`ifndef BBDT_DEFINES_VH
`define BBDT_DEFINES_VH
`define BBDT_ADDR_W 16
`define BBDT_OFF_TMO_LO 16'h413E
`define BBDT_OFF_TMO_HI 16'h413F
`define BBDT_OFF_STR_CFG 16'h4140
`define BBDT_OFF_STATUS 16'h4141
`define BBDT_OFF_CTRL 16'h4142
`define BBDT_RST_TMO_LO 8'hD0
`define BBDT_RST_TMO_HI 8'h07
`define BBDT_RST_ALT_IDX 4'h0
`define BBDT_RST_URL_IDX 4'h1
`define BBDT_RST_DETACH_CYC 8'h10
`define BBDT_CLK_HZ 200000000
`define BBDT_TICK_MS 10
`define BBDT_TICK_CYC ((`BBDT_CLK_HZ / 1000) * `BBDT_TICK_MS)
`define BBDT_ST_IDLE_BIT 0
`define BBDT_ST_RUN_BIT 1
`define BBDT_ST_DET_BIT 2
`define BBDT_ST_EXP_BIT 3
`endif

/* File: src/bbdt_tick_div.v */
// Divider making a one-cycle tick every 10 ms
`timescale 1ns/1ps
`include "bbdt_defines.vh"
module bbdt_tick_div #(
    parameter TICK_CYC = `BBDT_TICK_CYC
) (
    input wire ref_clk_i, // Core clock
    input wire reset_i,   // Async reset, active high
    input wire clear_i,   // Restart the period
    output reg tick_o     // One-cycle 10 ms pulse
);
    reg [31:0] cnt_reg;

    // Free count restarted on each new run so the first unit is whole
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= 32'h00000000;
            tick_o <= 1'b0;
        end else if (clear_i) begin
            cnt_reg <= 32'h00000000;
            tick_o <= 1'b0;
        end else if (cnt_reg == TICK_CYC - 1) begin
            cnt_reg <= 32'h00000000;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
            tick_o <= 1'b0;
        end
    end
endmodule

/* File: src/bbdt_timer.v */
// Billboard detach timer B: registers, unit counter and detach sequencer
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "bbdt_defines.vh"
module bbdt_timer #(
    parameter TICK_CYC = `BBDT_TICK_CYC,
    parameter DETACH_CYC = 8'h10
) (
    input wire ref_clk_i,                     // Core clock, 200 MHz
    input wire reset_i,                       // Async reset, active high
    input wire [`BBDT_ADDR_W-1:0] reg_addr_i, // Register address
    input wire [7:0] reg_wdata_i,             // Write data
    input wire reg_wr_i,                      // Write strobe
    input wire reg_rd_i,                      // Read strobe
    input wire alt_str_req_i,                 // Pulse: host asked alt-mode string
    input wire timer_a_expired_i,             // Pulse: address timer expired
    input wire billboard_active_i,            // Level: presented as billboard
    output reg [7:0] reg_rdata_o,             // Read data, cycle after strobe
    output reg detach_o,                      // Hold function disconnected
    output reg default_personality_o,         // Re-attach as default device
    output reg expired_o,                     // Pulse: timer B expired
    output reg [3:0] alt_str_idx_o,           // Alt-mode string index
    output reg [3:0] url_str_idx_o            // Additional-info URL index
);
    localparam ST_IDLE = 2'b00;
    localparam ST_RUN = 2'b01;
    localparam ST_DET = 2'b10;

    reg [7:0] tmo_lo_reg;
    reg [7:0] tmo_hi_reg;
    reg [7:0] det_len_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] units_reg;
    reg [7:0] det_cnt_reg;
    reg exp_sticky_reg;
    wire tick;
    wire start;
    wire [15:0] tmo;

    assign tmo = {tmo_hi_reg, tmo_lo_reg};
    assign start = alt_str_req_i && billboard_active_i;

    function sel;
        input [`BBDT_ADDR_W-1:0] a;
        input [`BBDT_ADDR_W-1:0] off;
        begin
            sel = (a == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Unit tick, restarted with every string request made while billboard is active
    bbdt_tick_div #(
        .TICK_CYC(TICK_CYC)
    ) u_div (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clear_i(start || state_reg != ST_RUN),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tmo_lo_reg <= `BBDT_RST_TMO_LO;
            tmo_hi_reg <= `BBDT_RST_TMO_HI;
            alt_str_idx_o <= `BBDT_RST_ALT_IDX;
            url_str_idx_o <= `BBDT_RST_URL_IDX;
            det_len_reg <= `BBDT_RST_DETACH_CYC;
        end else if (reg_wr_i) begin
            if (sel(reg_addr_i, `BBDT_OFF_TMO_LO)) begin
                tmo_lo_reg <= reg_wdata_i;
            end
            if (sel(reg_addr_i, `BBDT_OFF_TMO_HI)) begin
                tmo_hi_reg <= reg_wdata_i;
            end
            if (sel(reg_addr_i, `BBDT_OFF_STR_CFG)) begin
                alt_str_idx_o <= reg_wdata_i[3:0];
                url_str_idx_o <= reg_wdata_i[7:4];
            end
            if (sel(reg_addr_i, `BBDT_OFF_CTRL)) begin
                det_len_reg <= (reg_wdata_i == 8'h00) ? 8'h01 : reg_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reads; unmapped addresses return zero
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (sel(reg_addr_i, `BBDT_OFF_TMO_LO)) begin
                reg_rdata_o <= tmo_lo_reg;
            end else if (sel(reg_addr_i, `BBDT_OFF_TMO_HI)) begin
                reg_rdata_o <= tmo_hi_reg;
            end else if (sel(reg_addr_i, `BBDT_OFF_STR_CFG)) begin
                reg_rdata_o <= {url_str_idx_o, alt_str_idx_o};
            end else if (sel(reg_addr_i, `BBDT_OFF_STATUS)) begin
                reg_rdata_o <= {4'h0, exp_sticky_reg, state_reg == ST_DET,
                    state_reg == ST_RUN, state_reg == ST_IDLE};
            end else if (sel(reg_addr_i, `BBDT_OFF_CTRL)) begin
                reg_rdata_o <= det_len_reg;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: a zero timeout expires on the first tick
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (timer_a_expired_i) begin
                    state_next = ST_DET;
                end else if (start) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (timer_a_expired_i) begin
                    state_next = ST_DET;
                end else if (!start && tick && units_reg + 16'h0001 >= tmo) begin
                    state_next = ST_DET;
                end
            end
            ST_DET: begin
                if (det_cnt_reg == 8'h01) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Unit counter and detach pulse length
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            units_reg <= 16'h0000;
            det_cnt_reg <= 8'h00;
            detach_o <= 1'b0;
            default_personality_o <= 1'b0;
            expired_o <= 1'b0;
            exp_sticky_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            expired_o <= 1'b0;
            if (start || state_next != ST_RUN) begin
                units_reg <= 16'h0000;
            end else if (tick) begin
                units_reg <= units_reg + 16'h0001;
            end
            if (state_reg != ST_DET && state_next == ST_DET) begin
                det_cnt_reg <= det_len_reg;
                detach_o <= 1'b1;
                expired_o <= (state_reg == ST_RUN) && !timer_a_expired_i;
                exp_sticky_reg <= 1'b1;
            end else if (state_reg == ST_DET) begin
                det_cnt_reg <= det_cnt_reg - 8'h01;
                if (state_next == ST_IDLE) begin
                    detach_o <= 1'b0;
                    default_personality_o <= 1'b1;
                end
            end else if (reg_rd_i && sel(reg_addr_i, `BBDT_OFF_STATUS)) begin
                exp_sticky_reg <= 1'b0;
            end
            if (start && state_reg == ST_IDLE) begin
                default_personality_o <= 1'b0;
            end
        end
    end
endmodule

/* File: test/bbdt_host_model.sv */
// Host side model issuing alt-mode string requests
`timescale 1ns/1ps
module bbdt_host_model (
    input wire ref_clk_i,    // Core clock
    output reg alt_str_req_o // One-cycle string request
);
    initial alt_str_req_o = 1'b0;
    // One pulse, raised just after an edge, held until the next
    task send_req;
        begin
            alt_str_req_o <= 1'b1;
            @(posedge ref_clk_i);
            alt_str_req_o <= 1'b0;
        end
    endtask
endmodule

/* File: test/bbdt_timer_properties.sv */
// Checker for billboard detach timer B port behaviour
`timescale 1ns/1ps
module bbdt_timer_checker (
    input wire ref_clk_i, reset_i, reg_wr_i, reg_rd_i, // Clock, reset, strobes
    input wire alt_str_req_i, timer_a_expired_i, billboard_active_i, // Timer inputs
    input wire [15:0] reg_addr_i, // Register address
    input wire [7:0] reg_wdata_i, reg_rdata_o, // Data buses
    input wire detach_o, default_personality_o, expired_o // Timer outputs
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Bus answers and timer sequencing
    chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");
    chk_wr_readback: assert property (reg_wr_i && reg_addr_i == 16'h413E ##1 !reg_wr_i
        ##1 reg_rd_i && reg_addr_i == 16'h413E |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("low byte readback wrong");
    chk_expiry_detach: assert property (expired_o |-> detach_o)
        else $error("expiry without detach");
    chk_expiry_pulse: assert property (expired_o |=> !expired_o)
        else $error("expiry pulse too long");
    chk_timer_a_detach: assert property (timer_a_expired_i && !detach_o |-> ##[1:2] detach_o)
        else $error("timer A expiry ignored");
    chk_reattach_default: assert property ($fell(detach_o) |-> default_personality_o)
        else $error("reattach without default");
    chk_no_early: assert property (alt_str_req_i && billboard_active_i && !detach_o
        ##1 !timer_a_expired_i [*4] |-> !detach_o)
        else $error("detach too early");
    chk_default_cause: assert property ($rose(default_personality_o) |-> $past(detach_o))
        else $error("default without detach");
endmodule
bind bbdt_timer bbdt_timer_checker u_bbdt_timer_checker (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .alt_str_req_i(alt_str_req_i), .timer_a_expired_i(timer_a_expired_i),
    .billboard_active_i(billboard_active_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .detach_o(detach_o),
    .default_personality_o(default_personality_o), .expired_o(expired_o));

/* File: test/bbdt_timer_test.sv */
// Self-checking bench for billboard detach timer B
`timescale 1ns/1ps
module bbdt_timer_test;
    reg ref_clk_i, reset_i, reg_wr_i, reg_rd_i, timer_a_expired_i;
    reg billboard_i;
    reg [15:0] reg_addr_i;
    reg [7:0] reg_wdata_i;
    wire [7:0] reg_rdata_o;
    wire [3:0] alt_i, url_i;
    wire req, detach_o, pers_o, expired_o;
    integer error_cnt = 0;
    integer compares = 0;
    ////////////////////////////////////////////////////////////
    // Short tick keeps the 2000-unit default near 20000 cycles
    bbdt_timer #(.TICK_CYC(10)) u_bbdt_timer (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .alt_str_req_i(req), .timer_a_expired_i(timer_a_expired_i),
        .billboard_active_i(billboard_i), .reg_rdata_o(reg_rdata_o), .detach_o(detach_o),
        .default_personality_o(pers_o), .expired_o(expired_o), .alt_str_idx_o(alt_i),
        .url_str_idx_o(url_i));
    bbdt_host_model u_bbdt_host_model (.ref_clk_i(ref_clk_i), .alt_str_req_o(req));
    // Clock, 5 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // Count a compare, report a mismatch
    task check(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Bus cycles, a gap edge after each so strobes never toggle twice at once
    task wr(input [15:0] a, input [7:0] d);
        begin
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_wr_i <= 1'b1;
            @(posedge ref_clk_i);
            reg_wr_i <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask
    task rd(input [15:0] a, input [7:0] exp);
        begin
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            @(posedge ref_clk_i);
            reg_rd_i <= 1'b0;
            #1 check(reg_rdata_o, exp);
            @(posedge ref_clk_i);
        end
    endtask
    // Bounded wait for reattach, then the default personality
    task wait_attach;
        integer m;
        begin
            for (m = 0; detach_o !== 1'b0 && m < 64; m = m + 1) @(posedge ref_clk_i) #1;
            check(pers_o, 1);
            @(posedge ref_clk_i);
        end
    endtask
    // Start the timer, count cycles to detach; divider phase allows a few cycles slack
    task run_req(input integer units);
        integer n;
        begin
            u_bbdt_host_model.send_req;
            for (n = 0; detach_o !== 1'b1 && n < units * 10 + 20; n = n + 1)
                @(posedge ref_clk_i) #1;
            check(n >= units * 10 && n <= units * 10 + 3, 1);
            check(expired_o, 1);
            wait_attach;
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares %0d error_cnt %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Watchdog well past the 20000-cycle default run
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
    // Test sequence
    initial begin
        {reset_i, reg_wr_i, reg_rd_i, timer_a_expired_i} = 4'h8;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 8'h00;
        billboard_i = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(16'h413E, 8'hD0);
        rd(16'h413F, 8'h07);
        rd(16'h4150, 8'h00);
        wr(16'h413E, 8'h03);
        rd(16'h413E, 8'h03);
        wr(16'h413F, 8'h00);
        run_req(3);
        $display("short timeout test done");
        u_bbdt_host_model.send_req;
        #1 check(pers_o, 0);
        repeat (15) @(posedge ref_clk_i);
        run_req(3);
        $display("restart test done");
        timer_a_expired_i <= 1'b1;
        @(posedge ref_clk_i);
        timer_a_expired_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 check(detach_o, 1);
        wait_attach;
        $display("timer A test done");
        // Requests outside billboard presentation must not start the timer
        billboard_i <= 1'b0;
        u_bbdt_host_model.send_req;
        repeat (40) @(posedge ref_clk_i);
        #1 check(detach_o, 0);
        @(posedge ref_clk_i);
        billboard_i <= 1'b1;
        @(posedge ref_clk_i);
        $display("inactive request test done");
        wr(16'h4140, 8'h52);
        check({url_i, alt_i}, 8'h52);
        rd(16'h4140, 8'h52);
        wr(16'h413E, 8'hD0);
        wr(16'h413F, 8'h07);
        run_req(2000);
        $display("default timeout test done");
        tally_and_finish;
    end
endmodule
